// >>> prsp_engine_model.sv
`timescale 1ns/1ps
module prsp_engine_model
  import prsp_pkg::*;
(
  input  wire logic      aclk,
  output prsp_swap_req_t swap_req,
  output logic           policy_invoke
);
  initial begin
    policy_invoke = 1'b0;
    swap_req = '0;
  end
  // The request is withdrawn at once so it never pairs with a later invocation.
  task automatic invoke(input prsp_swap_req_t r);
    @(posedge aclk);
    policy_invoke <= 1'b1;
    swap_req <= r;
    @(posedge aclk);
    policy_invoke <= 1'b0;
    swap_req <= '0;
    #1;
  endtask
endmodule

// >>> prsp_pkg.sv
package prsp_pkg;

  // Register map. The printed offset 29h is not a multiple of four, so it is an index.
  localparam logic [7:0]  PRSP_PORT_CTRL_IDX = 8'h29;
  localparam logic [11:0] PRSP_PORT_CTRL_ADDR = {2'h0, PRSP_PORT_CTRL_IDX, 2'h0};
  localparam logic [11:0] PRSP_STATUS_ADDR    = 12'h0B0;

  // Field positions inside port_policy_control.
  localparam int PRSP_ACC_DATA_UFP_BIT = 12;
  localparam int PRSP_START_TO_SRC_BIT = 7;
  localparam int PRSP_ACC_TO_SRC_BIT   = 6;
  localparam int PRSP_START_TO_SNK_BIT = 5;
  localparam int PRSP_ACC_TO_SNK_BIT   = 4;
  localparam int PRSP_CUR_LO_BIT       = 0;
  localparam int PRSP_CUR_HI_BIT       = 1;

  // Implemented bits; reserved bits 11..8 and 3..2 and everything above 12 read zero.
  localparam logic [31:0] PRSP_CTRL_MASK  = 32'h0000_10F3;
  localparam logic [31:0] PRSP_CTRL_RESET = 32'h0000_1052;

  typedef enum logic [1:0] {
    PRSP_CUR_DEFAULT  = 2'h0,
    PRSP_CUR_1A5      = 2'h1,
    PRSP_CUR_3A0      = 2'h2,
    PRSP_CUR_RESERVED = 2'h3
  } prsp_cur_t;

  typedef enum logic [1:0] {
    PRSP_RESP_OK     = 2'h0,
    PRSP_RESP_SLVERR = 2'h2
  } prsp_resp_t;

  // Swap request from the policy engine and the policy snapshot taken at each invocation.
  typedef struct packed {
    logic to_data_ufp;
    logic to_source;
    logic to_sink;
  } prsp_swap_req_t;

  typedef struct packed {
    logic accept_data_ufp;
    logic start_to_source;
    logic accept_to_source;
    logic start_to_sink;
    logic accept_to_sink;
    logic [1:0] cur_sel;
  } prsp_policy_t;

endpackage

// >>> prsp_port_policy.sv
`timescale 1ns/1ps
// Function
// RL1 - Accept-to-UFP bit decides data-role swap answer
// RL2 - Start-to-source bit starts swaps while sink
// RL3 - Accept-to-source bit decides power swap answer
// RL4 - Start-to-sink bit starts swaps while source
// RL5 - Accept-to-sink bit decides power swap answer
// RL6 - Current field selects default, 1.5A, 3.0A
// RL7 - Ignore current unless source enabled and active
// RL8 - Explicit contract drives collision-avoidance Rp instead
// RL9 - Supply low forces default current advertisement
// RL10 - Writes act only at next policy invocation
module prsp_port_policy
  import prsp_pkg::*;
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [11:0]    s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [11:0]    s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic           policy_invoke,
  input  wire prsp_swap_req_t swap_req,
  input  wire logic           is_sink,
  input  wire logic           is_source,
  input  wire logic           source_enabled,
  input  wire logic           explicit_contract,
  input  wire logic [1:0]     collision_rp_sel,
  input  wire logic           supply_5v_input,
  output logic                swap_decision_valid,
  output logic                swap_accept,
  output logic                swap_reject,
  output logic                start_power_swap,
  output logic [1:0]          rp_advertise
);

  logic [31:0]  ctrl_q;
  prsp_policy_t active_q;
  logic         aw_held_q;
  logic [11:0]  awaddr_q;
  logic         w_held_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         supply_ok;
  logic         do_write;
  logic [1:0]   rp_d;

  prsp_sync #(
    .WIDTH (1)
  ) u_supply_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (supply_5v_input),
    .sync_out (supply_ok)
  );

  // Address and data are caught independently and the write fires once both are held.
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      awaddr_q      <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Storing only; apart from the register readback, nothing sees the new value until the next invocation.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PRSP_CTRL_RESET;
    end else if (do_write && awaddr_q == PRSP_PORT_CTRL_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8] & PRSP_CTRL_MASK[b*8 +: 8]; // RL10
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PRSP_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == PRSP_PORT_CTRL_ADDR) ? PRSP_RESP_OK : PRSP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reads take one request at a time; arready is withheld while data waits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PRSP_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                       (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready));
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (s_axi_araddr == PRSP_PORT_CTRL_ADDR) begin
          s_axi_rdata <= ctrl_q;
          s_axi_rresp <= PRSP_RESP_OK;
        end else if (s_axi_araddr == PRSP_STATUS_ADDR) begin
          s_axi_rdata <= {25'h0, active_q};
          s_axi_rresp <= PRSP_RESP_OK;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= PRSP_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // The policy engine samples the register only when it invokes a policy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // The snapshot starts out equal to the register's own reset fields.
      active_q <= prsp_policy_t'({PRSP_CTRL_RESET[PRSP_ACC_DATA_UFP_BIT],
                                  PRSP_CTRL_RESET[PRSP_START_TO_SRC_BIT:PRSP_ACC_TO_SNK_BIT],
                                  PRSP_CTRL_RESET[PRSP_CUR_HI_BIT:PRSP_CUR_LO_BIT]});
    end else if (policy_invoke) begin
      active_q.accept_data_ufp  <= ctrl_q[PRSP_ACC_DATA_UFP_BIT]; // RL10
      active_q.start_to_source  <= ctrl_q[PRSP_START_TO_SRC_BIT];
      active_q.accept_to_source <= ctrl_q[PRSP_ACC_TO_SRC_BIT];
      active_q.start_to_sink    <= ctrl_q[PRSP_START_TO_SNK_BIT];
      active_q.accept_to_sink   <= ctrl_q[PRSP_ACC_TO_SNK_BIT];
      active_q.cur_sel          <= ctrl_q[PRSP_CUR_HI_BIT:PRSP_CUR_LO_BIT];
    end
  end

  // Swap answers use the policy as it stood at the invocation that carried the request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swap_decision_valid <= 1'b0;
      swap_accept         <= 1'b0;
      swap_reject         <= 1'b0;
    end else begin
      swap_decision_valid <= policy_invoke && (|swap_req);
      swap_accept <= 1'b0;
      swap_reject <= 1'b0;
      if (policy_invoke) begin
        if (swap_req.to_data_ufp) begin
          swap_accept <= ctrl_q[PRSP_ACC_DATA_UFP_BIT]; // RL1
          swap_reject <= !ctrl_q[PRSP_ACC_DATA_UFP_BIT]; // RL1
        end else if (swap_req.to_source) begin
          swap_accept <= ctrl_q[PRSP_ACC_TO_SRC_BIT]; // RL3
          swap_reject <= !ctrl_q[PRSP_ACC_TO_SRC_BIT]; // RL3
        end else if (swap_req.to_sink) begin
          swap_accept <= ctrl_q[PRSP_ACC_TO_SNK_BIT]; // RL5
          swap_reject <= !ctrl_q[PRSP_ACC_TO_SNK_BIT]; // RL5
        end
      end
    end
  end

  // A one-cycle request to start a power-role swap, only when the current role allows it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_power_swap <= 1'b0;
    end else begin
      start_power_swap <= policy_invoke && !(|swap_req) &&
                          ((is_sink && ctrl_q[PRSP_START_TO_SRC_BIT]) || // RL2
                           (is_source && ctrl_q[PRSP_START_TO_SNK_BIT])); // RL4
    end
  end

  always_comb begin
    rp_d = rp_advertise;
    if (policy_invoke) begin
      if (!supply_ok) begin
        rp_d = PRSP_CUR_DEFAULT; // RL9
      end else if (explicit_contract) begin
        rp_d = collision_rp_sel; // RL8
      end else if (!(source_enabled && is_source)) begin
        rp_d = PRSP_CUR_DEFAULT; // RL7
      end else begin
        case (ctrl_q[PRSP_CUR_HI_BIT:PRSP_CUR_LO_BIT])
          PRSP_CUR_1A5: rp_d = PRSP_CUR_1A5; // RL6
          PRSP_CUR_3A0: rp_d = PRSP_CUR_3A0; // RL6
          default:      rp_d = PRSP_CUR_DEFAULT; // RL6
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rp_advertise <= PRSP_CUR_DEFAULT;
    end else begin
      rp_advertise <= rp_d;
    end
  end

endmodule

// >>> prsp_port_policy_chk.sv
`timescale 1ns/1ps
module prsp_port_policy_chk
  import prsp_pkg::*;
(
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           policy_invoke,
  input wire prsp_swap_req_t swap_req,
  input wire logic           is_sink,
  input wire logic           is_source,
  input wire logic           source_enabled,
  input wire logic           explicit_contract,
  input wire logic [1:0]     collision_rp_sel,
  input wire logic           supply_5v_input,
  input wire logic           swap_decision_valid,
  input wire logic           swap_accept,
  input wire logic           swap_reject,
  input wire logic           start_power_swap,
  input wire logic [1:0]     rp_advertise
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  dec_pulse_a: assert property (policy_invoke && (|swap_req) |=> swap_decision_valid)
    else $error("no decision");
  one_answer_a: assert property (swap_decision_valid |-> swap_accept != swap_reject)
    else $error("bad answer");
  no_request_a: assert property (policy_invoke && !(|swap_req) |=> !swap_decision_valid)
    else $error("stray decision");
  start_idle_a: assert property (policy_invoke && !is_sink && !is_source |=> !start_power_swap)
    else $error("stray start");
  start_busy_a: assert property (policy_invoke && (|swap_req) |=> !start_power_swap)
    else $error("start while busy");
  hold_rp_a: assert property (!policy_invoke |=> $stable(rp_advertise))
    else $error("rp moved");
  no_source_a: assert property (policy_invoke && !explicit_contract &&
    !(source_enabled && is_source) |=> rp_advertise == 2'h0) else $error("rp not source");
  // The supply pin is synchronised, so it must sit low for three edges before it counts.
  supply_low_a: assert property (!supply_5v_input [*3] ##0 policy_invoke |=> rp_advertise == 2'h0)
    else $error("rp supply low");
  contract_rp_a: assert property (supply_5v_input [*3] ##0 (policy_invoke &&
    explicit_contract && source_enabled && is_source) |=> rp_advertise == $past(collision_rp_sel))
    else $error("rp contract");
endmodule

bind prsp_port_policy prsp_port_policy_chk i_prsp_port_policy_chk (.aclk, .aresetn,
  .policy_invoke, .swap_req, .is_sink, .is_source, .source_enabled, .explicit_contract,
  .collision_rp_sel, .supply_5v_input, .swap_decision_valid, .swap_accept, .swap_reject,
  .start_power_swap, .rp_advertise);

// >>> prsp_sync.sv
`timescale 1ns/1ps
module prsp_sync
  import prsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin
    $error("prsp_sync needs WIDTH of at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// >>> test_port_role_swap_policy_config.sv
`timescale 1ns/1ps
module test_port_role_swap_policy_config;
  import prsp_pkg::*;
  logic           aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic           s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic           s_axi_rvalid, policy_invoke, is_sink, is_source, source_enabled;
  logic           explicit_contract, supply_5v_input, swap_decision_valid, swap_accept;
  logic           swap_reject, start_power_swap;
  logic [11:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]    s_axi_wdata, s_axi_rdata, d;
  logic [3:0]     s_axi_wstrb;
  logic [1:0]     s_axi_bresp, s_axi_rresp, collision_rp_sel, rp_advertise, r;
  prsp_swap_req_t swap_req;
  int             n_errors, n_checks, cyc;
  prsp_port_policy i_prsp_port_policy (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .policy_invoke, .swap_req,
    .is_sink, .is_source, .source_enabled, .explicit_contract, .collision_rp_sel,
    .supply_5v_input, .swap_decision_valid, .swap_accept, .swap_reject, .start_power_swap,
    .rp_advertise);
  prsp_engine_model i_prsp_engine_model (.aclk, .swap_req, .policy_invoke);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      give_verdict;
    end
  end
  task ck(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, collision_rp_sel} = '0;
    {is_sink, is_source, source_enabled, explicit_contract} = '0;
    supply_5v_input = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PRSP_PORT_CTRL_ADDR);
    ck(d, PRSP_CTRL_RESET);
    rd(PRSP_STATUS_ADDR);
    ck({r, d}, {PRSP_RESP_OK, 32'h0000_0056});
    rd(12'h010);
    ck({r, d}, {PRSP_RESP_SLVERR, 32'h0});
    wr(12'h010, 32'h0);
    ck(r, PRSP_RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(PRSP_PORT_CTRL_ADDR, 32'h0);
      for (int j = 0; j < 3; j++) begin
        i_prsp_engine_model.invoke(3'b100 >> j);
        ck({swap_decision_valid, swap_accept, swap_reject}, {1'b1, k == 0, k == 1});
      end
    end
    wr(PRSP_PORT_CTRL_ADDR, 32'hFFFF_FFFF);
    rd(PRSP_PORT_CTRL_ADDR);
    ck(d, PRSP_CTRL_MASK);
    // Only the low byte is enabled, so bit 12 in the next byte must survive.
    s_axi_wstrb <= 4'h1;
    wr(PRSP_PORT_CTRL_ADDR, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(PRSP_PORT_CTRL_ADDR);
    ck({r, d}, {PRSP_RESP_OK, 32'h0000_1000});
    wr(PRSP_PORT_CTRL_ADDR, 32'h80);
    is_sink <= 1'b1;
    i_prsp_engine_model.invoke('0);
    ck(start_power_swap, 1'b1);
    @(posedge aclk);
    is_sink <= 1'b0;
    is_source <= 1'b1;
    source_enabled <= 1'b1;
    i_prsp_engine_model.invoke('0);
    ck(start_power_swap, 1'b0);
    for (int c = 0; c < 4; c++) begin
      d = rp_advertise;
      wr(PRSP_PORT_CTRL_ADDR, 32'h20 | c);
      @(negedge aclk);
      ck(rp_advertise, d);
      i_prsp_engine_model.invoke('0);
      ck({start_power_swap, rp_advertise}, {1'b1, (c == 3) ? 2'h0 : 2'(c)});
    end
    rd(PRSP_STATUS_ADDR);
    ck(d, 32'h0000_000B);
    wr(PRSP_PORT_CTRL_ADDR, 32'h2);
    source_enabled <= 1'b0;
    i_prsp_engine_model.invoke('0);
    ck(rp_advertise, 2'h0);
    source_enabled <= 1'b1;
    explicit_contract <= 1'b1;
    collision_rp_sel <= 2'h1;
    i_prsp_engine_model.invoke('0);
    ck(rp_advertise, 2'h1);
    explicit_contract <= 1'b0;
    supply_5v_input <= 1'b0;
    repeat (3) @(posedge aclk);
    i_prsp_engine_model.invoke('0);
    ck(rp_advertise, 2'h0);
    give_verdict;
  end
endmodule
